//--- verilog/esc_regs.sv
// Purpose : Control, status and self-test registers of an entropy source, plus sampler
// Assumes : Avalon-MM slave, byte addresses, full-word accesses only
// Notes   : One wait state on every access; oscillator pins are asynchronous
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module esc_regs
  import esc_pkg::*;
(
  input  wire logic        clk,                      // System clock, 20 MHz
  input  wire logic        resetn,                   // Asynchronous reset, active low
  input  wire logic [7:0]  avs_address,              // Byte address
  input  wire logic        avs_read,                 // Read request
  input  wire logic        avs_write,                // Write request
  input  wire logic [31:0] avs_writedata,            // Write data
  input  wire logic [3:0]  avs_byteenable,           // Must be all ones
  output logic      [31:0] avs_readdata,             // Read data
  output logic             avs_waitrequest,          // Stall
  output logic      [1:0]  avs_response,             // OK or slave error
  input  wire logic        osc_raw_in,               // Raw ring oscillator bit
  input  wire logic        internal_fault_in,        // Internal bit fault pin
  input  wire logic        second_oscillator_fail_flag_in,             // Second oscillator failed
  input  wire logic        freq_fail_in,             // Frequency counter failure
  input  wire logic        freq_valid_in,            // Frequency count valid
  input  wire logic [1:0]  oscillator_select_mode,   // Oscillator mode select
  output logic             osc_enable,               // Ring oscillator run
  output logic      [1:0]  osc_divide                // Ring oscillator divide select
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [4:0] sync1_reg;
  logic [4:0] sync2_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {freq_valid_in, freq_fail_in, second_oscillator_fail_flag_in, internal_fault_in, osc_raw_in};
      sync2_reg <= sync1_reg;
    end
  end
  logic raw_bit;
  logic fault_s;
  logic osc2f_s;
  logic ffail_s;
  logic fval_s;
  assign raw_bit = sync2_reg[0];
  assign fault_s = sync2_reg[1];
  assign osc2f_s = sync2_reg[2];
  assign ffail_s = sync2_reg[3];
  assign fval_s  = sync2_reg[4];

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  logic        ack_reg;
  logic        req;
  logic        wr_acc;
  logic        rd_acc;
  logic        full_word;
  assign req       = avs_read | avs_write;
  assign full_word = (avs_byteenable == 4'hF);
  assign avs_waitrequest = req & ~ack_reg;
  assign wr_acc = avs_write & ack_reg & full_word;
  assign rd_acc = avs_read & ack_reg;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic        prog_reg;
  logic        acc_reg;
  logic [1:0]  div_reg;
  logic [3:0]  retry_reg;
  logic [7:0]  lrun_reg;
  logic [15:0] poker_range_field_reg;
  logic [23:0] poker_maximum_field_reg;
  logic [15:0] sample_length_clocks_reg;
  logic [15:0] samp_reg;
  logic [9:0]  discard_run_limit_reg;
  logic        wr_main;
  logic        may_cfg;
  logic        do_def;
  logic        do_dis;
  logic        wr_prog;
  assign wr_main = wr_acc && avs_address == OFS_MAIN_CTL;
  assign may_cfg = prog_reg | avs_writedata[B_PROG];
  assign do_def = wr_main & may_cfg & avs_writedata[B_RSTDEF];
  assign do_dis = wr_main & may_cfg & avs_writedata[B_DISCHK] & ~avs_writedata[B_RSTDEF];
  assign wr_prog = wr_acc & prog_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prog_reg <= 1'b1;
      acc_reg  <= 1'b0;
    end else if (wr_main) begin
      prog_reg <= avs_writedata[B_PROG];
      acc_reg  <= avs_writedata[B_ACC];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_reg <= RST_DIV;
    end else if (do_def) begin
      div_reg <= RST_DIV;
    end else if (do_dis) begin
      div_reg <= DIS_DIV;
    end else if (wr_main && may_cfg) begin
      div_reg <= avs_writedata[B_DIV_LO +: 2];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      retry_reg   <= RST_RETRY;
      lrun_reg    <= RST_LRUN;
      poker_range_field_reg <= RST_POKER_RANGE_FIELD;
      poker_maximum_field_reg <= RST_POKER_MAXIMUM_FIELD;
      samp_reg    <= RST_SAMP;
      discard_run_limit_reg   <= RST_DISCARD_RUN_LIMIT;
    end else if (do_def) begin
      retry_reg   <= RST_RETRY;
      lrun_reg    <= RST_LRUN;
      poker_range_field_reg <= RST_POKER_RANGE_FIELD;
      poker_maximum_field_reg <= RST_POKER_MAXIMUM_FIELD;
      samp_reg    <= RST_SAMP;
      discard_run_limit_reg   <= RST_DISCARD_RUN_LIMIT;
    end else if (do_dis) begin
      retry_reg   <= DIS_RETRY;
      lrun_reg    <= DIS_LRUN;
      poker_range_field_reg <= DIS_POKER_RANGE_FIELD;
      poker_maximum_field_reg <= DIS_POKER_MAXIMUM_FIELD;
      discard_run_limit_reg   <= DIS_DISCARD_RUN_LIMIT;
    end else if (wr_prog) begin
      if (avs_address == OFS_RETRY_LRUN) begin
        retry_reg <= avs_writedata[19:16];
        lrun_reg  <= avs_writedata[7:0];
      end else if (avs_address == OFS_PKR_RANGE) begin
        poker_range_field_reg <= avs_writedata[15:0];
      end else if (avs_address == OFS_POKER_MAXIMUM_FIELD_SQ) begin
        poker_maximum_field_reg <= avs_writedata[23:0];
      end else if (avs_address == OFS_SAMP_TIME) begin
        samp_reg <= avs_writedata[15:0];
      end else if (avs_address == OFS_DISCARD) begin
        discard_run_limit_reg <= avs_writedata[9:0];
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sample_length_clocks_reg <= RST_SAMPLE_LENGTH_CLOCKS;
    end else if (wr_prog && avs_address == OFS_SAMP_TIME) begin
      sample_length_clocks_reg <= avs_writedata[31:16];
    end
  end

  // ----------------------------------------------------------------
  // Error and status flags (a set wins over a clear)
  // ----------------------------------------------------------------
  logic fault_reg;
  logic fcfail_reg;
  logic chk_err_reg;
  logic err_clr;
  logic chk_err_set;
  logic fcfail_set;
  assign err_clr = wr_main & avs_writedata[B_ERR];
  assign fcfail_set = ffail_s | (osc2f_s & oscillator_select_mode == MODE_DUAL);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fault_reg <= 1'b0;
    end else if (fault_s) begin
      fault_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fcfail_reg  <= 1'b0;
      chk_err_reg <= 1'b0;
    end else begin
      fcfail_reg  <= fcfail_set | (fcfail_reg & ~err_clr);
      chk_err_reg <= chk_err_set | (chk_err_reg & ~err_clr);
    end
  end

  // ----------------------------------------------------------------
  // Sampling engine
  // ----------------------------------------------------------------
  esc_gen_state_t st_reg;
  logic [15:0]  dly_cnt_reg;
  logic [15:0]  smp_cnt_reg;
  logic [19:0]  tot_reg;
  logic [7:0]   run_reg;
  logic         lrun_fail_reg;
  logic         prev_reg;
  logic         half_reg;
  logic         first_reg;
  logic [9:0]   disc_reg;
  logic [3:0]   nib_reg;
  logic [1:0]   nib_cnt_reg;
  logic [3:0]   tries_reg;
  logic [255:0] ent_reg;
  logic         valid_reg;
  logic         sample_now;
  logic         accept;
  logic         discard;
  logic         sparse_fail;
  logic         pkr_fail;
  logic         chk_fail;
  logic         start;
  logic         restart;
  logic         last_output_word_rd;
  logic [15:0]  dly_end;
  esc_pkr_if    pk();

  assign dly_end    = (sample_length_clocks_reg == 16'h0000) ? 16'h0000 : sample_length_clocks_reg - 1'b1;
  assign sample_now = st_reg == GEN_SAMPLE && dly_cnt_reg == dly_end;
  assign discard    = sample_now & half_reg & (first_reg == raw_bit);
  assign accept     = sample_now & half_reg & (first_reg != raw_bit);
  assign sparse_fail = discard & (10'(disc_reg + 1'b1) > discard_run_limit_reg);
  // minimum is max - range + 1
  assign pkr_fail = pk.result == 24'h00_0000 || pk.result >= 24'(poker_range_field_reg);
  assign chk_fail = lrun_fail_reg | pkr_fail;
  assign start    = st_reg == GEN_IDLE & acc_reg & ~prog_reg & ~valid_reg & ~chk_err_reg;
  assign restart  = start | (st_reg == GEN_CHECK & chk_fail & tries_reg != 4'h0);
  assign chk_err_set = (sparse_fail & ~prog_reg)
                     | (st_reg == GEN_CHECK & ~prog_reg & chk_fail & tries_reg == 4'h0);
  assign last_output_word_rd  = rd_acc & ~prog_reg & avs_address == OFS_ENT_LAST;

  assign pk.clear   = restart;
  assign pk.max_lim = poker_maximum_field_reg;
  assign pk.nib_vld = accept & nib_cnt_reg == 2'd3;
  assign pk.nib     = {nib_reg[2:0], first_reg};

  esc_poker #(.CW(16)) u_poker (
    .clk    (clk),
    .resetn (resetn),
    .pk     (pk)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_reg    <= GEN_IDLE;
      tries_reg <= '0;
    end else if (prog_reg) begin
      st_reg <= GEN_IDLE;
    end else begin
      case (st_reg)
        GEN_IDLE: begin
          if (start) begin
            st_reg    <= GEN_SAMPLE;
            tries_reg <= retry_reg;
          end
        end
        GEN_SAMPLE: begin
          if (sparse_fail) begin
            st_reg <= GEN_IDLE;
          end else if (sample_now && 16'(smp_cnt_reg + 1'b1) >= samp_reg) begin
            st_reg <= GEN_CHECK;
          end
        end
        GEN_CHECK: begin
          if (chk_fail && tries_reg != 4'h0) begin
            st_reg    <= GEN_SAMPLE;
            tries_reg <= tries_reg - 1'b1;
          end else begin
            st_reg <= GEN_IDLE;
          end
        end
        default: begin
          st_reg <= GEN_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dly_cnt_reg   <= '0;
      smp_cnt_reg   <= '0;
      run_reg       <= '0;
      lrun_fail_reg <= 1'b0;
      prev_reg      <= 1'b0;
      half_reg      <= 1'b0;
      first_reg     <= 1'b0;
      disc_reg      <= '0;
      nib_reg       <= '0;
      nib_cnt_reg   <= '0;
    end else if (restart) begin
      dly_cnt_reg   <= '0;
      smp_cnt_reg   <= '0;
      run_reg       <= '0;
      lrun_fail_reg <= 1'b0;
      half_reg      <= 1'b0;
      disc_reg      <= '0;
      nib_cnt_reg   <= '0;
    end else if (st_reg == GEN_SAMPLE) begin
      dly_cnt_reg <= sample_now ? 16'h0000 : dly_cnt_reg + 1'b1;
      if (sample_now) begin
        smp_cnt_reg <= smp_cnt_reg + 1'b1;
        prev_reg    <= raw_bit;
        if (run_reg != 8'hFF) begin
          run_reg <= (raw_bit == prev_reg || run_reg == 8'h00) ? run_reg + 1'b1 : 8'h01;
        end
        if (raw_bit == prev_reg && run_reg >= lrun_reg && run_reg != 8'h00) begin
          lrun_fail_reg <= 1'b1;
        end
        half_reg  <= ~half_reg;
        first_reg <= half_reg ? first_reg : raw_bit;
        if (discard) begin
          disc_reg <= disc_reg + 1'b1;
        end else if (accept) begin
          disc_reg    <= '0;
          nib_reg     <= {nib_reg[2:0], first_reg};
          nib_cnt_reg <= nib_cnt_reg + 1'b1;
        end
      end
    end
  end

  // Entropy store and total samples
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ent_reg <= '0;
      tot_reg <= '0;
    end else if (start) begin
      tot_reg <= '0;
    end else if (sample_now) begin
      tot_reg <= tot_reg + 1'b1;
      if (accept) begin
        ent_reg <= {ent_reg[254:0], first_reg};
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      valid_reg <= 1'b0;
    end else if (st_reg == GEN_CHECK && !chk_fail && acc_reg && !prog_reg) begin
      valid_reg <= 1'b1;
    end else if (last_output_word_rd) begin
      valid_reg <= 1'b0;
    end
  end

  assign osc_enable = st_reg != GEN_IDLE;
  assign osc_divide = div_reg;

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  logic [31:0] rd_next;
  logic        miss_next;
  logic [31:0] rdata_reg;
  logic [1:0]  resp_reg;
  logic [2:0]  word_idx;
  assign word_idx = avs_address[4:2];
  always_comb begin
    rd_next   = 32'h0000_0000;
    miss_next = 1'b0;
    if (avs_address == OFS_MAIN_CTL) begin
      rd_next[B_FAULT]  = fault_reg;
      rd_next[B_PROG]   = prog_reg;
      rd_next[B_OSC2F]  = osc2f_s;
      rd_next[B_STOPOK] = ~osc_enable | prog_reg;
      rd_next[B_ERR]    = chk_err_reg | fcfail_reg;
      rd_next[B_VALID]  = valid_reg;
      rd_next[B_FCVAL]  = fval_s;
      rd_next[B_FCFAIL] = fcfail_reg;
      rd_next[B_ACC]    = acc_reg;
      rd_next[B_DIV_LO +: 2] = div_reg;
    end else if (avs_address == OFS_RETRY_LRUN) begin
      rd_next = prog_reg ? {12'h000, retry_reg, 8'h00, lrun_reg} : 32'h0000_0000;
    end else if (avs_address == OFS_PKR_RANGE) begin
      rd_next = prog_reg ? {16'h0000, poker_range_field_reg} : 32'h0000_0000;
    end else if (avs_address == OFS_POKER_MAXIMUM_FIELD_SQ) begin
      rd_next = {8'h00, prog_reg ? poker_maximum_field_reg : pk.result};
    end else if (avs_address == OFS_SAMP_TIME) begin
      rd_next = prog_reg ? {sample_length_clocks_reg, samp_reg} : 32'h0000_0000;
    end else if (avs_address == OFS_DISCARD) begin
      rd_next = prog_reg ? {22'h00_0000, discard_run_limit_reg} : {12'h000, tot_reg};
    end else if (avs_address >= OFS_ENT_FIRST && avs_address <= OFS_ENT_LAST) begin
      rd_next = prog_reg ? 32'h0000_0000 : ent_reg[32*(7 - word_idx) +: 32];
    end else begin
      miss_next = 1'b1;
    end
    if (avs_address[1:0] != 2'b00 || !full_word) begin
      miss_next = 1'b1;
      rd_next   = 32'h0000_0000;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= '0;
      resp_reg  <= RESP_OK;
    end else if (req && !ack_reg) begin
      rdata_reg <= avs_read ? rd_next : 32'h0000_0000;
      resp_reg  <= miss_next ? RESP_SLVERR : RESP_OK;
    end
  end
  assign avs_readdata = rdata_reg;
  assign avs_response = resp_reg;
endmodule
`default_nettype wire

//--- verilog/esc_pkg.sv
// Purpose : Shared offsets, fields, defaults and states of the entropy control block
// Assumes : 32-bit register bus, byte addresses, one word per register
// Notes   : Defaults restored by the restore-defaults action come from here
package esc_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_MAIN_CTL   = 8'h00;
  localparam logic [7:0] OFS_RETRY_LRUN = 8'h04;
  localparam logic [7:0] OFS_PKR_RANGE  = 8'h08;
  localparam logic [7:0] OFS_POKER_MAXIMUM_FIELD_SQ = 8'h0C;
  localparam logic [7:0] OFS_SAMP_TIME  = 8'h10;
  localparam logic [7:0] OFS_DISCARD    = 8'h14;
  localparam logic [7:0] OFS_ENT_FIRST  = 8'h40;
  localparam logic [7:0] OFS_ENT_LAST   = 8'h5C;

  // ----------------------------------------------------------------
  // Main control/status bit positions
  // ----------------------------------------------------------------
  localparam int B_FAULT   = 31;
  localparam int B_PROG    = 16;
  localparam int B_OSC2F   = 15;
  localparam int B_STOPOK  = 13;
  localparam int B_ERR     = 12;
  localparam int B_VALID   = 10;
  localparam int B_FCVAL   = 9;
  localparam int B_FCFAIL  = 8;
  localparam int B_RSTDEF  = 6;
  localparam int B_ACC     = 5;
  localparam int B_DISCHK  = 4;
  localparam int B_DIV_LO  = 2;

  // ----------------------------------------------------------------
  // Reset values and disable-checks values
  // ----------------------------------------------------------------
  localparam logic [3:0]  RST_RETRY    = 4'h1;
  localparam logic [7:0]  RST_LRUN     = 8'h1F;
  localparam logic [15:0] RST_POKER_RANGE_FIELD  = 16'h023A;
  localparam logic [23:0] RST_POKER_MAXIMUM_FIELD  = 24'h00_023A;
  localparam logic [15:0] RST_SAMPLE_LENGTH_CLOCKS  = 16'h0C80;
  localparam logic [15:0] RST_SAMP     = 16'h0200;
  localparam logic [9:0]  RST_DISCARD_RUN_LIMIT    = 10'h03F;
  localparam logic [1:0]  RST_DIV      = 2'h0;
  localparam logic [3:0]  DIS_RETRY    = 4'h1;
  localparam logic [7:0]  DIS_LRUN     = 8'hFF;
  localparam logic [15:0] DIS_POKER_RANGE_FIELD  = 16'hFFFF;
  localparam logic [23:0] DIS_POKER_MAXIMUM_FIELD  = 24'h00_FFFF;
  localparam logic [1:0]  DIS_DIV      = 2'h0;
  localparam logic [9:0]  DIS_DISCARD_RUN_LIMIT    = 10'h03F;

  localparam logic [1:0] MODE_DUAL     = 2'b01;
  localparam logic [1:0] RESP_OK       = 2'b00;
  localparam logic [1:0] RESP_SLVERR   = 2'b10;

  typedef enum logic [1:0] {GEN_IDLE, GEN_SAMPLE, GEN_CHECK} esc_gen_state_t;
endpackage

//--- verilog/esc_pkr_if.sv
// Purpose : Carries nibbles and poker limits between the generator and the poker unit
// Assumes : Single clock domain
// Notes   : None
`timescale 1ns/1ps
`default_nettype none
interface esc_pkr_if;
  logic        clear;   // Restart test, load the maximum
  logic [23:0] max_lim; // Starting value
  logic        nib_vld; // One completed nibble
  logic [3:0]  nib;     // Nibble value
  logic [23:0] result;  // Running square result
  modport gen (output clear, output max_lim, output nib_vld, output nib, input result);
  modport pkr (input clear, input max_lim, input nib_vld, input nib, output result);
endinterface
`default_nettype wire

//--- verilog/esc_poker.sv
// Purpose : Poker square calculation over 4-bit nibbles
// Assumes : Counters never wrap within one generation
// Notes   : Sum of squares is built incrementally, (c+1)^2 - c^2 = 2c+1
`timescale 1ns/1ps
`default_nettype none
module esc_poker
  import esc_pkg::*;
#(
  parameter int CW = 16
) (
  input  wire logic clk,    // System clock
  input  wire logic resetn, // Asynchronous reset, active low
  esc_pkr_if.pkr    pk      // Nibble stream and result
);
  // Counter width must leave room for 2c+1 in the 24-bit result
  if (CW < 1 || CW > 22) begin : g_bad_cw
    $error("esc_poker: CW out of range");
  end

  logic [CW-1:0] cnt_reg [16];
  logic [CW-1:0] cur;
  logic [23:0]   step;
  logic [23:0]   sq_reg;

  // ----------------------------------------------------------------
  // Per-nibble occurrence counters
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_cnt
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          cnt_reg[gi] <= '0;
        end else if (pk.clear) begin
          cnt_reg[gi] <= '0;
        end else if (pk.nib_vld && pk.nib == 4'(gi)) begin
          cnt_reg[gi] <= cnt_reg[gi] + 1'b1;
        end
      end
    end
  endgenerate

  assign cur  = cnt_reg[pk.nib];
  assign step = 24'({cur, 1'b1});

  // ----------------------------------------------------------------
  // Square result, counts down from the maximum
  // ----------------------------------------------------------------
  // decreasing square result
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sq_reg <= '0;
    end else if (pk.clear) begin
      sq_reg <= pk.max_lim;
    end else if (pk.nib_vld) begin
      sq_reg <= (sq_reg > step) ? sq_reg - step : '0;
    end
  end

  assign pk.result = sq_reg;
endmodule
`default_nettype wire

//--- verif/esc_regs_assertions.sv
// Purpose: Port properties of esc_regs
// Assumes: Full-word accesses only
// Notes: Program bit is mirrored from completed writes
`timescale 1ns/1ps
`default_nettype none
module esc_chk
  import esc_pkg::*;
(
  input wire logic        clk,               // Clock
  input wire logic        resetn,            // Reset
  input wire logic [7:0]  avs_address,       // Address
  input wire logic        avs_read,          // Read
  input wire logic        avs_write,         // Write
  input wire logic [31:0] avs_writedata,     // Data in
  input wire logic [31:0] avs_readdata,      // Data out
  input wire logic        avs_waitrequest,   // Stall
  input wire logic        internal_fault_in, // Fault
  input wire logic        osc_enable,        // Run
  input wire logic [1:0]  osc_divide         // Divide
);
  logic prog_reg;
  wire  w0 = avs_write && !avs_waitrequest && avs_address == OFS_MAIN_CTL;
  wire  wp = w0 && (prog_reg || avs_writedata[B_PROG]);
  wire  rr = avs_read && !avs_waitrequest;
  wire  r0 = rr && avs_address == OFS_MAIN_CTL;
  wire  d4 = avs_writedata[B_RSTDEF] || avs_writedata[B_DISCHK];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) prog_reg <= 1'b1;
    else if (w0) prog_reg <= avs_writedata[B_PROG];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // One cycle of slack: an abort lands one edge after the write's own edge
  a_prog_stops: assert property (prog_reg && $past(prog_reg) |-> !osc_enable)
    else $error("oscillator runs in program mode");
  a_div_load: assert property (wp && !d4 |=> osc_divide == $past(avs_writedata[3:2]))
    else $error("divider not loaded");
  a_div_hold: assert property (!$stable(osc_divide) |-> $past(wp))
    else $error("divider changed without program write");
  a_div_clear: assert property (wp && d4 |=> osc_divide == 2'b00)
    else $error("divider not cleared");
  a_stop_ok: assert property ((!osc_enable)[*2] ##0 r0 |-> avs_readdata[B_STOPOK])
    else $error("safe-to-stop low while idle");
  a_self_clr: assert property (r0 |-> !avs_readdata[B_RSTDEF] && !avs_readdata[B_DISCHK])
    else $error("self-clearing bit reads one");
  a_run_zero: assert property (rr && !prog_reg && avs_address == OFS_RETRY_LRUN
    |-> avs_readdata == 32'h0000_0000) else $error("limits readable in run mode");
  a_fault_seen: assert property (r0 && $past(internal_fault_in, 5) |-> avs_readdata[B_FAULT])
    else $error("internal fault not shown");
  c_run: cover property (osc_enable);
  c_dflt: cover property (wp && avs_writedata[B_RSTDEF]);
  c_fault: cover property (r0 && avs_readdata[B_FAULT]);
endmodule
bind esc_regs esc_chk u_esc_chk (.clk, .resetn, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_readdata, .avs_waitrequest, .internal_fault_in, .osc_enable,
  .osc_divide);
`default_nettype wire

//--- verif/esc_regs_tb.sv
// Purpose: Self-checking bench of esc_regs
// Assumes: Answer time is taken from waitrequest
// Notes: Generation is started and then aborted
`timescale 1ns/1ps
`default_nettype none
module esc_regs_tb;
  import esc_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] r, w, e;} esc_row_t;
  esc_row_t rows [6] = '{'{8'h00, 32'h0001_2000, 32'h0001_0008, 32'h0001_2008},
    '{8'h04, 32'h0001_001F, 32'h000A_0055, 32'h000A_0055},
    '{8'h08, 32'h0000_023A, 32'h0000_1234, 32'h0000_1234},
    '{8'h0C, 32'h0000_023A, 32'h0012_3456, 32'h0012_3456},
    '{8'h10, 32'h0C80_0200, 32'h0010_0040, 32'h0010_0040},
    '{8'h14, 32'h0000_003F, 32'h0000_0155, 32'h0000_0155}};
  logic        clk = 0, resetn = 0, rd = 0, wr = 0, f31 = 0, f15 = 0, raw = 0, tgl = 0, wt, oen;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wd = 32'h0000_0000, q, qd;
  logic [1:0]  mode = 2'b00, rsp, dv;
  int          errors = 0, checked = 0, polls;
  always #25 clk = ~clk;
  always @(posedge clk) begin
    if (tgl) raw <= ~raw;
  end
  esc_regs u_esc_regs (.clk, .resetn, .avs_address(adr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wd), .avs_byteenable(4'hF), .avs_readdata(qd), .avs_waitrequest(wt),
    .avs_response(rsp), .osc_raw_in(raw), .internal_fault_in(f31), .second_oscillator_fail_flag_in(f15),
    .freq_fail_in(1'b0), .freq_valid_in(1'b0), .oscillator_select_mode(mode),
    .osc_enable(oen), .osc_divide(dv));
  task automatic conclude();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Request stands until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0000_0000);
    int n;
    n = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wt !== 1'b0 && n < 20);
    q = qd;
    rd <= 1'b0;
    wr <= 1'b0;
    if (wt !== 1'b0) begin
      errors++;
      conclude();
    end
    @(negedge clk);
  endtask
  task automatic vchk(input logic [31:0] e [5]);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 8'(4 * i + 4));
      chk(q, e[i]);
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b0, rows[i].a);
      chk(q, rows[i].r);
      bus(1'b1, rows[i].a, rows[i].w);
      bus(1'b0, rows[i].a);
      chk(q, rows[i].e);
    end
    chk(32'(dv), 32'h0000_0002);
    bus(1'b1, 8'h00, 32'h0001_0010);
    vchk('{32'h0001_00FF, 32'h0000_FFFF, 32'h0000_FFFF, 32'h0010_0040, 32'h0000_003F});
    chk(32'(dv), 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_0004);
    for (int a = 4; a <= 16; a += 4) begin
      if (a != 12) begin
        bus(1'b0, 8'(a));
        chk(q, 32'h0000_0000);
      end
    end
    bus(1'b1, 8'h00, 32'h0000_0008);
    chk(32'(dv), 32'h0000_0001);
    bus(1'b1, 8'h00, 32'h0001_0040);
    vchk('{32'h0001_001F, 32'h0000_023A, 32'h0000_023A, 32'h0010_0200, 32'h0000_003F});
    bus(1'b0, 8'h30);
    chk(q, 32'h0000_0000);
    chk(32'(rsp), 32'(RESP_SLVERR));
    @(posedge clk);
    f31 <= 1'b1;
    f15 <= 1'b1;
    repeat (2) @(posedge clk);
    bus(1'b0, 8'h00);
    chk(q, 32'h8001_A000);
    @(posedge clk);
    mode <= MODE_DUAL;
    bus(1'b0, 8'h00);
    chk(q, 32'h8001_B100);
    @(posedge clk);
    f15 <= 1'b0;
    bus(1'b1, 8'h00, 32'h0001_0000);
    bus(1'b0, 8'h00);
    chk(q, 32'h8001_3100);
    bus(1'b1, 8'h00, 32'h0001_1000);
    bus(1'b0, 8'h00);
    chk(q, 32'h8001_2000);
    bus(1'b1, 8'h00, 32'h0000_0020);
    repeat (3) @(negedge clk);
    chk(32'(oen), 32'h0000_0001);
    bus(1'b0, 8'h00);
    chk(q, 32'h8000_0020);
    @(posedge clk);
    f31 <= 1'b0;
    bus(1'b1, 8'h00, 32'h0001_0020);
    @(negedge clk);
    chk(32'(oen), 32'h0000_0000);
    bus(1'b0, 8'h00);
    chk(q, 32'h8001_2020);
    bus(1'b1, OFS_DISCARD, 32'h0000_0002);
    bus(1'b1, OFS_SAMP_TIME, 32'h0001_0040);
    bus(1'b1, OFS_POKER_MAXIMUM_FIELD_SQ, 32'h0000_0050);
    bus(1'b1, OFS_PKR_RANGE, 32'h0000_0020);
    // Raw input stuck low: every pair is discarded
    bus(1'b1, 8'h00, 32'h0000_0020);
    repeat (20) @(negedge clk);
    bus(1'b0, 8'h00);
    chk(q, 32'h8000_3020);
    bus(1'b0, OFS_DISCARD);
    chk(q, 32'h0000_0006);
    // Alternating raw input: every pair kept, one bit value throughout
    tgl <= 1'b1;
    bus(1'b1, 8'h00, 32'h0000_1020);
    polls = 0;
    do begin
      bus(1'b0, 8'h00);
      polls++;
    end while (q[B_VALID] !== 1'b1 && polls < 40);
    chk(q, 32'h8000_2420);
    bus(1'b0, OFS_POKER_MAXIMUM_FIELD_SQ);
    chk(q, 32'h0000_0010);
    bus(1'b0, OFS_DISCARD);
    chk(q, 32'h0000_0040);
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, 8'(OFS_ENT_FIRST + 4 * i));
      chk(q, 32'h0000_0000);
    end
    bus(1'b0, OFS_ENT_LAST);
    chk(32'(q == 32'h0000_0000 || q == 32'hFFFF_FFFF), 32'h0000_0001);
    bus(1'b0, 8'h00);
    chk(q, 32'h8000_0020);
    conclude();
  end
endmodule
`default_nettype wire
